// ==== rtl/slpcg_pkg.sv ====
package slpcg_pkg;

	typedef enum logic [5:0] {
		M_NONE  = 6'h01,
		M_IDLE  = 6'h02,
		M_ADCNR = 6'h04,
		M_PDOWN = 6'h08,
		M_PSAVE = 6'h10,
		M_STBY  = 6'h20
	} slpcg_mode_t;

	typedef enum logic [2:0] {
		S_RUN   = 3'h1,
		S_SLEEP = 3'h2,
		S_WAKE  = 3'h4
	} slpcg_state_t;

	// =========================================================
	// mode decode and timing
	localparam slpcg_mode_t MODE_TABLE [8] = '{
		M_IDLE, M_ADCNR, M_PDOWN, M_PSAVE, M_NONE, M_NONE, M_STBY, M_NONE};
	localparam logic [2:0] SMS_STBY      = 3'h6;
	localparam logic [2:0] WAKE_CYC_STBY = 3'h6;
	localparam logic [2:0] WAKE_CYC_FAST = 3'h1;

	// =========================================================
	// register map
	localparam logic [7:0] OFS_CTRL   = 8'h00;
	localparam logic [7:0] OFS_TCFG   = 8'h04;
	localparam logic [7:0] OFS_TMASK  = 8'h08;
	localparam logic [7:0] OFS_ECFG   = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_ISTS   = 8'h14;
	localparam logic [7:0] OFS_IMASK  = 8'h18;
	localparam int         IEV_WAKE   = 0;
	localparam int         IEV_ENTER  = 1;
	localparam int         IEV_REFUSE = 2;
	localparam logic [3:0] CTRL_RST   = 4'h0;
	localparam logic [1:0] TCFG_RST   = 2'h0;
	localparam logic [1:0] TMASK_RST  = 2'h0;
	localparam logic [1:0] ECFG_RST   = 2'h0;
	localparam logic [2:0] IRQ_RST    = 3'h0;
	localparam logic [1:0] EXT_RST    = 2'h3;

	// =========================================================
	// carriers
	typedef struct packed {
		logic cpu;
		logic flash;
		logic io;
		logic adc;
		logic asy;
		logic main_osc;
		logic tmr_osc;
		logic sync_tmr;
	} slpcg_gate_t;

	typedef struct packed {
		logic pin_chg;
		logic two_wire_slave;
		logic tmr_ovf;
		logic tmr_cmp;
		logic nvm_rdy;
		logic adc;
		logic wdt;
		logic other_io;
	} slpcg_src_t;

	typedef struct packed {
		logic       tmr_en;
		logic       tmr_async;
		logic       ovf_ie;
		logic       cmp_ie;
		logic [1:0] lvl;
		logic       gie;
	} slpcg_cfg_t;

	typedef struct packed {
		logic       xtal;
		logic [2:0] sleep_mode_select;
	} slpcg_ctrl_t;

	typedef struct packed {
		slpcg_state_t st;
		slpcg_mode_t  mode;
		logic [2:0]   cnt;
		slpcg_gate_t  gate;
		slpcg_ctrl_t  ctrl;
		logic [1:0]   tcfg;
		logic [1:0]   async_timer_irq_mask;
		logic [1:0]   lvl;
		logic [2:0]   ists;
		logic [2:0]   imask;
		logic         irq;
		logic [31:0]  prdata;
		logic [1:0]   s1;
		logic [1:0]   s2;
		logic [1:0]   s3;
		logic [1:0]   flt;
		logic [1:0]   flt_d;
	} slpcg_regs_t;

endpackage

// ==== rtl/slpcg_wake_decode.sv ====
`timescale 1ns/1ps
module slpcg_wake_decode
	import slpcg_pkg::*;
(
	input  wire slpcg_mode_t mode,     // mode in force, M_NONE while running
	input  wire slpcg_cfg_t  cfg,      // timer, mask and trigger setup
	input  wire slpcg_src_t  src,      // on-chip wake requests
	input  wire logic [1:0]  ext_low,  // filtered external irq pins low
	input  wire logic [1:0]  ext_edge, // filtered external irq pin change
	output      slpcg_gate_t gate,     // clock and oscillator enables
	output      logic        wake      // accepted wake request
);

	logic       t_asy;
	logic       t_syn;
	logic       t_irq;
	logic       deep_set;
	logic       mid_set;
	logic [1:0] ext_w;

	assign t_asy = cfg.tmr_en & cfg.tmr_async;
	assign t_syn = cfg.tmr_en & ~cfg.tmr_async;
	assign t_irq = cfg.gie & ((src.tmr_ovf & cfg.ovf_ie) | (src.tmr_cmp & cfg.cmp_ie));

	genvar i;
	generate
		for (i = 0; i < 2; i++) begin : g_ext
			assign ext_w[i] = cfg.lvl[i] ? ext_low[i] : (ext_edge[i] & (mode == M_IDLE));
		end
	endgenerate

	assign deep_set = (|ext_w) | src.pin_chg | src.two_wire_slave | src.wdt;
	assign mid_set  = deep_set | t_irq | src.nvm_rdy | src.adc;

	// =========================================================
	// gate order: cpu flash io adc asy main_osc tmr_osc sync_tmr
	always_comb begin
		gate = '0;
		wake = 1'b0;
		case (mode)
			M_NONE: begin
				gate = {5'h1F, 1'b1, t_asy, 1'b0};
			end
			M_IDLE: begin
				gate = {5'h07, 1'b1, t_asy, 1'b0};
				wake = mid_set | src.other_io;
			end
			M_ADCNR: begin
				gate = {5'h03, 1'b1, t_asy, 1'b0};
				wake = mid_set;
			end
			M_PDOWN: begin
				gate = '0;
				wake = deep_set;
			end
			M_PSAVE: begin
				gate = {5'h01, t_syn, t_asy, t_syn};
				wake = deep_set | t_irq;
			end
			M_STBY: begin
				gate = {5'h00, 1'b1, 1'b0, 1'b0};
				wake = deep_set;
			end
			default: begin
				gate = '0;
				wake = 1'b1;
			end
		endcase
	end

endmodule // slpcg_wake_decode

// ==== rtl/slpcg_top.sv ====
// The address map and the APB register port were left to the implementer.
`timescale 1ns/1ps
module slpcg_top
	import slpcg_pkg::*;
(
	input  wire logic        pclk,                // system clock, 200 MHz
	input  wire logic        presetn,             // async reset, active low
	input  wire logic        psel,                // apb select
	input  wire logic        penable,             // apb access phase
	input  wire logic        pwrite,              // apb write
	input  wire logic [7:0]  paddr,               // apb byte address
	input  wire logic [31:0] pwdata,              // apb write data
	output      logic [31:0] prdata,              // apb read data
	output      logic        pready,              // apb ready
	output      logic        pslverr,             // apb error, unmapped
	input  wire logic        sleep_exec,          // sleep instruction pulse
	input  wire logic        cpu_status_word_gie, // global irq enable
	input  wire logic        external_irq_zero_n, // irq pin zero
	input  wire logic        external_irq_one_n,  // irq pin one
	input  wire slpcg_src_t  src,                 // on-chip wake sources
	output      slpcg_gate_t clk_gate,            // clock and oscillator enables
	output      logic        sleeping,            // core is asleep
	output      logic        irq                  // event interrupt
);

	slpcg_regs_t r_ff;
	slpcg_regs_t nxt_r;
	slpcg_cfg_t  cfg;
	slpcg_mode_t req_mode;
	slpcg_mode_t b_mode;
	slpcg_gate_t a_gate;
	slpcg_gate_t b_gate;
	logic        a_wake;
	logic        acc;
	logic        setup;
	logic        bad;
	logic        wr;
	logic [2:0]  iev;

	assign cfg = '{tmr_en: r_ff.tcfg[0], tmr_async: r_ff.tcfg[1],
		ovf_ie: r_ff.async_timer_irq_mask[0], cmp_ie: r_ff.async_timer_irq_mask[1],
		lvl: r_ff.lvl, gie: cpu_status_word_gie};

	assign req_mode = (r_ff.ctrl.sleep_mode_select == SMS_STBY && !r_ff.ctrl.xtal) ? M_PDOWN
		: MODE_TABLE[r_ff.ctrl.sleep_mode_select];
	// b side shows the gate to go to: sleep target or running
	assign b_mode   = (r_ff.st == S_RUN) ? req_mode : M_NONE;

	// =========================================================
	// decoders
	slpcg_wake_decode u_cur (
		.mode     (r_ff.mode),
		.cfg      (cfg),
		.src      (src),
		.ext_low  (~r_ff.flt),
		.ext_edge (r_ff.flt ^ r_ff.flt_d),
		.gate     (a_gate),
		.wake     (a_wake)
	);

	slpcg_wake_decode u_nxt (
		.mode     (b_mode),
		.cfg      (cfg),
		.src      (src),
		.ext_low  (~r_ff.flt),
		.ext_edge (r_ff.flt ^ r_ff.flt_d),
		.gate     (b_gate),
		.wake     ()
	);

	// =========================================================
	// apb slave, zero wait states
	assign acc     = psel & penable;
	assign setup   = psel & ~penable;
	assign bad     = !(paddr inside {OFS_CTRL, OFS_TCFG, OFS_TMASK, OFS_ECFG,
		OFS_STATUS, OFS_ISTS, OFS_IMASK});
	assign wr      = acc & pwrite & ~bad;
	assign pready  = 1'b1;
	assign pslverr = acc & bad;
	assign prdata  = r_ff.prdata;

	// =========================================================
	// state update
	always_comb begin
		nxt_r = r_ff;
		iev   = 3'h0;
		// pins pass three flops; change taken once stages two and three agree
		nxt_r.s1    = {external_irq_one_n, external_irq_zero_n};
		nxt_r.s2    = r_ff.s1;
		nxt_r.s3    = r_ff.s2;
		nxt_r.flt   = ((r_ff.s2 ~^ r_ff.s3) & r_ff.s3) | ((r_ff.s2 ^ r_ff.s3) & r_ff.flt);
		nxt_r.flt_d = r_ff.flt;

		if (setup) begin
			case (paddr)
				OFS_CTRL:   nxt_r.prdata = {28'h0, r_ff.ctrl};
				OFS_TCFG:   nxt_r.prdata = {30'h0, r_ff.tcfg};
				OFS_TMASK:  nxt_r.prdata = {30'h0, r_ff.async_timer_irq_mask};
				OFS_ECFG:   nxt_r.prdata = {30'h0, r_ff.lvl};
				OFS_STATUS: nxt_r.prdata = {15'h0, r_ff.gate, r_ff.mode, r_ff.st};
				OFS_ISTS:   nxt_r.prdata = {29'h0, r_ff.ists};
				OFS_IMASK:  nxt_r.prdata = {29'h0, r_ff.imask};
				default:    nxt_r.prdata = 32'h0;
			endcase
		end
		if (wr) begin
			case (paddr)
				OFS_CTRL:  nxt_r.ctrl = pwdata[3:0];
				OFS_TCFG:  nxt_r.tcfg = pwdata[1:0];
				OFS_TMASK: nxt_r.async_timer_irq_mask = pwdata[1:0];
				OFS_ECFG:  nxt_r.lvl = pwdata[1:0];
				OFS_IMASK: nxt_r.imask = pwdata[2:0];
				default: begin
				end
			endcase
		end

		case (r_ff.st)
			S_RUN: begin
				nxt_r.gate = a_gate;
				if (sleep_exec) begin
					if (req_mode == M_NONE) begin
						iev[IEV_REFUSE] = 1'b1;
					end else begin
						nxt_r.st   = S_SLEEP;
						nxt_r.mode = req_mode;
						nxt_r.gate = b_gate;
						iev[IEV_ENTER] = 1'b1;
					end
				end
			end
			S_SLEEP: begin
				nxt_r.gate = a_gate;
				if (a_wake) begin
					nxt_r.st = S_WAKE;
					nxt_r.cnt = (r_ff.mode == M_STBY) ? WAKE_CYC_STBY : WAKE_CYC_FAST;
					iev[IEV_WAKE] = 1'b1;
				end
			end
			S_WAKE: begin
				nxt_r.gate = a_gate;
				if (r_ff.cnt == WAKE_CYC_FAST) begin
					nxt_r.st   = S_RUN;
					nxt_r.mode = M_NONE;
					nxt_r.gate = b_gate;
				end else begin
					nxt_r.cnt = r_ff.cnt - 3'h1;
				end
			end
			default: begin
				nxt_r.st   = S_RUN;
				nxt_r.mode = M_NONE;
			end
		endcase

		// a new event beats a write-one clear in the same cycle
		nxt_r.ists = (r_ff.ists & ~((wr && paddr == OFS_ISTS) ? pwdata[2:0] : 3'h0)) | iev;
		nxt_r.irq  = |(nxt_r.ists & nxt_r.imask);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r_ff       <= '0;
			r_ff.st    <= S_RUN;
			r_ff.mode  <= M_NONE;
			r_ff.gate  <= {5'h1F, 1'b1, 1'b0, 1'b0};
			r_ff.ctrl  <= CTRL_RST;
			r_ff.tcfg  <= TCFG_RST;
			r_ff.async_timer_irq_mask <= TMASK_RST;
			r_ff.lvl   <= ECFG_RST;
			r_ff.ists  <= IRQ_RST;
			r_ff.imask <= IRQ_RST;
			r_ff.s1    <= EXT_RST;
			r_ff.s2    <= EXT_RST;
			r_ff.s3    <= EXT_RST;
			r_ff.flt   <= EXT_RST;
			r_ff.flt_d <= EXT_RST;
		end else begin
			r_ff <= nxt_r;
		end
	end

	assign clk_gate = r_ff.gate;
	assign sleeping = (r_ff.st != S_RUN);
	assign irq      = r_ff.irq;

	// =========================================================
	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	psave_timer_a: assert property (
		r_ff.st == S_SLEEP && r_ff.mode == M_PSAVE && r_ff.tcfg[0] |=> clk_gate.asy)
		else $error("async domain stopped in power-save");

	tmr_wake_a: assert property (
		r_ff.st == S_SLEEP && r_ff.mode == M_PSAVE && cpu_status_word_gie
		&& src.tmr_ovf && r_ff.async_timer_irq_mask[0] |=> r_ff.st == S_WAKE)
		else $error("enabled timer overflow did not wake");

	psave_osc_a: assert property (
		r_ff.st == S_SLEEP && r_ff.mode == M_PSAVE && !r_ff.tcfg[1] |=> !clk_gate.tmr_osc)
		else $error("timer oscillator left on in power-save");

	psave_main_a: assert property (
		r_ff.st == S_SLEEP && r_ff.mode == M_PSAVE && !(r_ff.tcfg[0] && !r_ff.tcfg[1])
		|=> !clk_gate.main_osc)
		else $error("main source left on in power-save");

	sync_only_a: assert property (
		r_ff.st == S_SLEEP && r_ff.mode == M_PSAVE && r_ff.tcfg[0] && !r_ff.tcfg[1]
		|=> clk_gate.main_osc && clk_gate.sync_tmr
		&& !clk_gate.cpu && !clk_gate.flash && !clk_gate.io && !clk_gate.adc)
		else $error("sync clock leaks beyond timer");

	stby_entry_a: assert property (
		r_ff.st == S_RUN && sleep_exec && r_ff.ctrl.sleep_mode_select == SMS_STBY
		&& r_ff.ctrl.xtal |=> r_ff.st == S_SLEEP && r_ff.mode == M_STBY)
		else $error("standby not entered");

	stby_gate_a: assert property (
		r_ff.st == S_SLEEP && r_ff.mode == M_STBY
		|-> clk_gate == slpcg_gate_t'({5'h00, 1'b1, 1'b0, 1'b0}))
		else $error("standby gating wrong");

	stby_resume_a: assert property (
		r_ff.st == S_SLEEP && r_ff.mode == M_STBY && a_wake
		|=> !clk_gate.cpu [*6] ##1 clk_gate.cpu)
		else $error("standby resume not six cycles");

	pdown_gate_a: assert property (
		r_ff.st == S_SLEEP && r_ff.mode == M_PDOWN |-> clk_gate == '0)
		else $error("clock running in power-down");

	idle_osc_a: assert property (
		r_ff.st == S_SLEEP && r_ff.mode == M_IDLE && !(r_ff.tcfg[0] && r_ff.tcfg[1])
		|=> !clk_gate.tmr_osc && clk_gate.io)
		else $error("idle oscillator gating wrong");

	idle_wake_a: assert property (
		r_ff.st == S_SLEEP && r_ff.mode == M_IDLE && src.other_io |=> r_ff.st == S_WAKE)
		else $error("idle ignored other io wake");

	edge_quiet_a: assert property (
		r_ff.st == S_SLEEP && (r_ff.mode == M_PDOWN || r_ff.mode == M_STBY)
		&& r_ff.lvl == 2'h0 && !src.pin_chg && !src.two_wire_slave && !src.wdt
		|=> r_ff.st == S_SLEEP)
		else $error("woke on ignored source");

	undef_code_a: assert property (
		r_ff.st == S_RUN && sleep_exec && req_mode == M_NONE
		|=> r_ff.st == S_RUN && r_ff.ists[IEV_REFUSE])
		else $error("undefined code not refused");

	tmr_gie_a: assert property (
		r_ff.st == S_SLEEP && r_ff.mode == M_PSAVE && !cpu_status_word_gie
		&& r_ff.lvl == 2'h0 && !src.pin_chg && !src.two_wire_slave && !src.wdt
		|=> r_ff.st == S_SLEEP)
		else $error("timer woke without global enable");

	adcnr_quiet_a: assert property (
		r_ff.st == S_SLEEP && r_ff.mode == M_ADCNR && r_ff.lvl == 2'h0
		&& src == slpcg_src_t'(8'h01) |=> r_ff.st == S_SLEEP)
		else $error("adc quiet woke on other io");

	level_wake_a: assert property (
		r_ff.st == S_SLEEP && r_ff.mode == M_PDOWN && r_ff.lvl[0] && !r_ff.flt[0]
		|=> r_ff.st == S_WAKE)
		else $error("low level pin did not wake");

	adcnr_gate_a: assert property (
		r_ff.st == S_SLEEP && r_ff.mode == M_ADCNR
		|-> !clk_gate.cpu && !clk_gate.flash && !clk_gate.io && clk_gate.adc
		&& clk_gate.asy && clk_gate.main_osc)
		else $error("adc quiet gating wrong");

	stby_cycle_c: cover property (
		r_ff.st == S_SLEEP && r_ff.mode == M_STBY ##1 r_ff.st == S_WAKE);
	psave_tmr_c: cover property (
		r_ff.st == S_SLEEP && r_ff.mode == M_PSAVE && src.tmr_cmp ##1 r_ff.st == S_WAKE);
	idle_edge_c: cover property (
		r_ff.st == S_SLEEP && r_ff.mode == M_IDLE && (r_ff.flt != r_ff.flt_d));
	refuse_c: cover property (
		r_ff.st == S_RUN && sleep_exec && req_mode == M_NONE);
	lvl_wake_c: cover property (
		r_ff.st == S_SLEEP && r_ff.mode == M_PDOWN && r_ff.lvl[0] ##1 r_ff.st == S_WAKE);

endmodule // slpcg_top

// ==== sim/slpcg_core_model.sv ====
`timescale 1ns/1ps
// =========================================================
// core side: fetches, and so issues sleep, only on a running cpu clock
module slpcg_core_model
	import slpcg_pkg::*;
(
	input  wire logic        pclk,       // system clock
	input  wire logic        presetn,    // async reset, active low
	input  wire logic        go,         // bench asks for a sleep
	input  wire slpcg_gate_t clk_gate,   // gates from the block
	input  wire logic        sleeping,   // block asleep
	output      logic        sleep_exec  // one-cycle sleep pulse
);
	logic sleep_exec_ff;
	logic nxt_sleep_exec;

	// never two pulses in a row, a real core needs a fetch in between
	always_comb begin
		nxt_sleep_exec = go & clk_gate.cpu & ~sleeping & ~sleep_exec_ff;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sleep_exec_ff <= 1'b0;
		end else begin
			sleep_exec_ff <= nxt_sleep_exec;
		end
	end

	assign sleep_exec = sleep_exec_ff;
endmodule // slpcg_core_model

// ==== sim/sleep_mode_clock_gating_tb_top.sv ====
`timescale 1ns/1ps
module sleep_mode_clock_gating_tb_top
	import slpcg_pkg::*;
;
	typedef struct packed {
		logic [3:0] ctrl;
		logic [1:0] tcfg;
		logic [7:0] gate;
		logic [1:0] mask;
		logic       gie;
		logic [7:0] src;
		logic [4:0] n;
	} slpcg_row_t;

	// =========================================================
	// software choices; cases
	localparam slpcg_row_t ROWS [19] = '{
		'{4'h8, 2'h0, 8'h3C, 2'h0, 1'h1, 8'h01, 5'h02},
		'{4'h9, 2'h0, 8'h1C, 2'h0, 1'h1, 8'h01, 5'h14},
		'{4'h9, 2'h0, 8'h1C, 2'h0, 1'h1, 8'h04, 5'h02},
		'{4'hA, 2'h0, 8'h00, 2'h0, 1'h1, 8'h04, 5'h14},
		'{4'hA, 2'h0, 8'h00, 2'h0, 1'h1, 8'h40, 5'h02},
		'{4'hB, 2'h0, 8'h08, 2'h0, 1'h1, 8'h80, 5'h02},
		'{4'hB, 2'h3, 8'h0A, 2'h3, 1'h1, 8'h10, 5'h02},
		'{4'hB, 2'h3, 8'h0A, 2'h0, 1'h1, 8'h20, 5'h14},
		'{4'hB, 2'h3, 8'h0A, 2'h1, 1'h0, 8'h20, 5'h14},
		'{4'hB, 2'h1, 8'h0D, 2'h1, 1'h1, 8'h20, 5'h02},
		'{4'hB, 2'h1, 8'h0D, 2'h0, 1'h1, 8'h08, 5'h14},
		'{4'hE, 2'h3, 8'h04, 2'h3, 1'h1, 8'h20, 5'h14},
		'{4'hE, 2'h0, 8'h04, 2'h0, 1'h1, 8'h02, 5'h07},
		'{4'h6, 2'h0, 8'h00, 2'h0, 1'h1, 8'h02, 5'h02},
		'{4'h8, 2'h3, 8'h3E, 2'h0, 1'h1, 8'h02, 5'h02},
		'{4'h9, 2'h1, 8'h1C, 2'h0, 1'h1, 8'h02, 5'h02},
		'{4'hC, 2'h0, 8'hFC, 2'h0, 1'h1, 8'h02, 5'h01},
		'{4'hD, 2'h0, 8'hFC, 2'h0, 1'h1, 8'h02, 5'h01},
		'{4'hF, 2'h0, 8'hFC, 2'h0, 1'h1, 8'h02, 5'h01}
	};

	logic        pclk    = 1'b0;
	logic        presetn = 1'b0;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [7:0]  paddr   = 8'h00;
	logic [31:0] pwdata  = 32'h0;
	logic        go      = 1'b0;
	logic        gie     = 1'b0;
	logic        irq0_n  = 1'b1;
	logic        irq1_n  = 1'b1;
	slpcg_src_t  src     = '0;
	logic [31:0] prdata;
	logic [31:0] dq;
	logic        pready;
	logic        pslverr;
	logic        perr;
	logic        sleep_exec;
	logic        sleeping;
	logic        irq;
	slpcg_gate_t clk_gate;
	int          miscompares = 0;
	int          n_checks = 0;

	always #2.5 pclk = ~pclk;

	slpcg_top DUT (
		.pclk                (pclk),
		.presetn             (presetn),
		.psel                (psel),
		.penable             (penable),
		.pwrite              (pwrite),
		.paddr               (paddr),
		.pwdata              (pwdata),
		.prdata              (prdata),
		.pready              (pready),
		.pslverr             (pslverr),
		.sleep_exec          (sleep_exec),
		.cpu_status_word_gie (gie),
		.external_irq_zero_n (irq0_n),
		.external_irq_one_n  (irq1_n),
		.src                 (src),
		.clk_gate            (clk_gate),
		.sleeping            (sleeping),
		.irq                 (irq)
	);

	slpcg_core_model core (
		.pclk       (pclk),
		.presetn    (presetn),
		.go         (go),
		.clk_gate   (clk_gate),
		.sleeping   (sleeping),
		.sleep_exec (sleep_exec)
	);

	// =========================================================
	// shared tasks
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q);
		int k;
		k = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && k < 40) begin
			k++;
			@(posedge pclk);
		end
		if (k == 40) chk("pready", 32'h1, 32'h0);
		q = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic do_sleep;
		@(posedge pclk);
		go <= 1'b1;
		@(posedge pclk);
		go <= 1'b0;
		@(posedge pclk);
		#1;
	endtask

	// counts edges from the wake pulse until the cpu clock returns, 20 = none
	task automatic wake(input slpcg_src_t s, output int n);
		@(posedge pclk);
		src <= s;
		n = 0;
		do begin
			@(posedge pclk);
			src <= '0;
			#1;
			n++;
		end while (clk_gate.cpu !== 1'b1 && n < 20);
	endtask

	// =========================================================
	// scenarios
	task automatic reset_test;
		chk("gate_rst", 32'hFC, {24'h0, clk_gate});
		apb(1'b0, OFS_STATUS, 32'h0, dq);
		chk("status_rst", 32'h0001F809, dq);
		apb(1'b1, OFS_STATUS, 32'hFFFFFFFF, dq);
		apb(1'b0, OFS_STATUS, 32'h0, dq);
		chk("status_ro", 32'h0001F809, dq);
		apb(1'b0, OFS_CTRL, 32'h0, dq);
		chk("ctrl_rst", 32'h0, dq);
		apb(1'b0, 8'h1C, 32'h0, dq);
		chk("unmapped_data", 32'h0, dq);
		chk("unmapped_err", 32'h1, {31'h0, perr});
	endtask

	task automatic run_rows;
		int n;
		for (int i = 0; i < 19; i++) begin
			apb(1'b1, OFS_CTRL, {28'h0, ROWS[i].ctrl}, dq);
			apb(1'b1, OFS_TCFG, {30'h0, ROWS[i].tcfg}, dq);
			apb(1'b1, OFS_TMASK, {30'h0, ROWS[i].mask}, dq);
			gie <= ROWS[i].gie;
			do_sleep;
			chk("clk_gate", {24'h0, ROWS[i].gate}, {24'h0, clk_gate});
			wake(ROWS[i].src, n);
			chk("wake_cycles", {27'h0, ROWS[i].n}, n);
			if (n == 20) wake(8'h02, n);
			apb(1'b0, OFS_ISTS, 32'h0, dq);
			chk("ists", (ROWS[i].gate == 8'hFC) ? 32'h4 : 32'h3, dq);
			apb(1'b1, OFS_ISTS, 32'h7, dq);
		end
	endtask

	task automatic irq_test;
		int n;
		apb(1'b1, OFS_IMASK, 32'h2, dq);
		apb(1'b1, OFS_CTRL, 32'h0, dq);
		do_sleep;
		@(posedge pclk);
		#1;
		chk("irq_enter", 32'h1, {31'h0, irq});
		wake(8'h02, n);
		apb(1'b1, OFS_IMASK, 32'h4, dq);
		@(posedge pclk);
		#1;
		chk("irq_masked", 32'h0, {31'h0, irq});
		apb(1'b1, OFS_IMASK, 32'h2, dq);
		@(posedge pclk);
		#1;
		chk("irq_unmask", 32'h1, {31'h0, irq});
		apb(1'b1, OFS_ISTS, 32'h7, dq);
		@(posedge pclk);
		#1;
		chk("irq_clear", 32'h0, {31'h0, irq});
	endtask

	task automatic ext_test;
		int k;
		apb(1'b1, OFS_CTRL, 32'h2, dq);
		apb(1'b1, OFS_ECFG, 32'h0, dq);
		do_sleep;
		@(posedge pclk);
		irq0_n <= 1'b0;
		repeat (12) @(posedge pclk);
		#1;
		chk("edge_pd", 32'h1, {31'h0, sleeping});
		apb(1'b1, OFS_ECFG, 32'h1, dq);
		k = 0;
		while (sleeping === 1'b1 && k < 12) begin
			@(posedge pclk);
			#1;
			k++;
		end
		chk("level_pd", 32'h0, {31'h0, sleeping});
		@(posedge pclk);
		irq0_n <= 1'b1;
		apb(1'b1, OFS_CTRL, 32'h0, dq);
		apb(1'b1, OFS_ECFG, 32'h0, dq);
		repeat (8) @(posedge pclk);
		do_sleep;
		@(posedge pclk);
		irq1_n <= 1'b0;
		k = 0;
		while (sleeping === 1'b1 && k < 12) begin
			@(posedge pclk);
			#1;
			k++;
		end
		// idle takes an edge on the pin
		chk("edge_idle", 32'h0, {31'h0, sleeping});
		@(posedge pclk);
		irq1_n <= 1'b1;
	endtask

	// =========================================================
	// end of run
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	initial begin
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		reset_test;
		run_rows;
		irq_test;
		ext_test;
		wrap_up;
	end

	// whole run is well under a thousand cycles, so 20000 means a hang
	initial begin
		#100000;
		miscompares++;
		wrap_up;
	end
endmodule // sleep_mode_clock_gating_tb_top
